// file: bench/ptr_pm_model.sv
`timescale 1ns/10ps
// program memory stand-in, word one clock after a read
module ptr_pm_model (
    input wire logic clock,
    input wire logic pm_rd,
    input wire logic [10:0] pm_addr,
    output logic [15:0] pm_rdata
);
    initial pm_rdata = 16'h0000;
    always @(posedge clock) begin
        pm_rdata <= pm_rd ? {5'h15, pm_addr} ^ 16'h3C00 : ~pm_rdata;
    end
endmodule : ptr_pm_model

// file: bench/ptr_table_reader_assertions.sv
`timescale 1ns/10ps
// port-level checks for the table read unit
module ptr_table_reader_assertions
    import ptr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire ptr_pkg::ptr_req_s req,
    input wire logic req_ready,
    input wire logic busy,
    input wire logic done,
    input wire logic cycle_en,
    input wire logic hold_we,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] ptr_low,
    input wire logic [7:0] ptr_high,
    input wire logic [7:0] table_high_byte_hold,
    input wire logic pm_rd,
    input wire logic [10:0] pm_addr,
    input wire logic [15:0] pm_rdata,
    input wire logic dm_we,
    input wire ptr_pkg::ptr_dm_wr_s dm_wr,
    input wire logic prog_serial_data_line_oe,
    input wire logic debug_data_line_oe
);
    logic take;
    ptr_req_s cap;
    logic [10:0] cap_ptr;
    assign take = req_valid && req_ready && cycle_en;
    // request and pointers seen at the take edge
    always_ff @(posedge clock) begin
        if (take) begin
            cap <= req;
            cap_ptr <= {ptr_high[2:0], ptr_low};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_ADDR: assert property (pm_rd |-> pm_addr ==
        (cap.op[0] ? {3'h7, cap_ptr[7:0]} : cap_ptr))
        else $error("wrong fetch address");
    AST_FETCH: assert property (take |-> ##5 pm_rd)
        else $error("fetch not in second cycle");
    AST_DATA: assert property (pm_rd |-> ##2 dm_we &&
        $past(pm_rdata) == {table_high_byte_hold, dm_wr.data})
        else $error("fetched word not delivered");
    AST_DEST: assert property (dm_we |-> dm_wr.addr == cap.addr &&
        dm_wr.sector == (cap.op[1] ? cap.sector : 3'h0))
        else $error("wrong destination");
    AST_TWO: assert property (take |=> busy [*8] ##1 (done && !busy))
        else $error("instruction not two cycles");
    AST_PHASE: assert property (cycle_en |=>
        !cycle_en [*3] ##1 cycle_en)
        else $error("cycle enable not every four clocks");
    AST_HOLD: assert property (hold_we && !busy |=>
        table_high_byte_hold == $past(sfr_wdata))
        else $error("holding register write lost");
    AST_PINS: assert property (!prog_serial_data_line_oe &&
        !debug_data_line_oe)
        else $error("serial data line driven");
    COV_LAST: cover property (take &&
        req.op == EXTENDED_TABLE_READ_LAST_PAGE_OP);
    COV_SECT: cover property (dm_we && dm_wr.sector != 3'h0);
    COV_HOLD: cover property (hold_we && !busy);
endmodule : ptr_table_reader_assertions

bind ptr_table_reader ptr_table_reader_assertions chk (.*);

// file: bench/ptr_table_reader_tb.sv
`timescale 1ns/10ps
// self-checking bench for the table read unit
module ptr_table_reader_tb;
    import ptr_pkg::*;
    logic clock, rst, req_valid, req_ready, busy, done, cycle_en;
    logic ptr_low_we, ptr_high_we, hold_we, pm_rd, dm_we;
    logic in_circuit_programming, onchip_debug_support;
    logic prog_serial_data_line_in, prog_serial_data_line_out;
    logic prog_serial_data_line_oe, prog_serial_clock_line;
    logic debug_data_line_in, debug_data_line_out, debug_data_line_oe;
    logic debug_clock_line;
    logic [7:0] sfr_wdata, ptr_low, ptr_high, table_high_byte_hold;
    logic [10:0] pm_addr;
    logic [15:0] pm_rdata;
    ptr_req_s req;
    ptr_dm_wr_s dm_wr;
    int failures, compares;
    ptr_table_reader dut (.*);
    ptr_pm_model pm (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic final_report;
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [15:0] exp, got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // a wait that ran out
    task automatic tmo;
        $display("Error wait expected event seen timeout");
        failures++;
        final_report();
    endtask : tmo
    // one-clock write strobe: 0 low pointer, 1 high pointer, 2 hold
    task automatic wr(input int sel, input logic [7:0] v);
        @(posedge clock);
        sfr_wdata <= v;
        {ptr_low_we, ptr_high_we, hold_we} <= 3'h4 >> sel;
        @(posedge clock);
        {ptr_low_we, ptr_high_we, hold_we} <= 3'h0;
    endtask : wr
    // one table read, checked at data write and completion
    task automatic tab(input ptr_op_e op, input logic [2:0] sec,
                       input logic [7:0] dst, input logic [10:0] a);
        logic [15:0] w;
        int n;
        w = {5'h15, a} ^ 16'h3C00;
        n = 0;
        @(posedge clock);
        req <= '{op, sec, dst};
        req_valid <= 1'b1;
        do begin
            @(negedge clock);
            n++;
        end while (!(cycle_en && req_ready) && n < 9);
        if (!(cycle_en && req_ready)) tmo();
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!dm_we && n < 20);
        if (!dm_we) tmo();
        chk("dm latency", 7, n);
        chk("fetch addr", a, pm_addr);
        chk("dm sector", op[1] ? sec : 3'h0, dm_wr.sector);
        chk("dm addr", dst, dm_wr.addr);
        chk("dm data", w[7:0], dm_wr.data);
        chk("hold", w[15:8], table_high_byte_hold);
        do begin
            @(negedge clock);
            n++;
        end while (!done && n < 20);
        chk("done at", 9, n);
        chk("busy", 0, busy);
    endtask : tab
    task automatic t_reset;
        @(negedge clock);
        chk("pointers", 0, {ptr_high, ptr_low});
        chk("hold", 0, table_high_byte_hold);
        chk("ready", 1, {busy, dm_we, pm_rd, req_ready});
    endtask : t_reset
    // every variant, high pointer bits above the range set
    task automatic t_ops;
        logic [7:0] lo;
        for (int i = 0; i < 4; i++) begin
            lo = {i[1:0], 6'h3F};
            wr(0, lo);
            wr(1, 8'hFD);
            tab(ptr_op_e'(i), 3'h5, {6'h20, i[1:0]},
                i[0] ? {3'h7, lo} : {3'h5, lo});
        end
    endtask : t_ops
    task automatic t_hold;
        wr(2, 8'hA5);
        @(negedge clock);
        chk("hold write", 8'hA5, table_high_byte_hold);
    endtask : t_hold
    // requests during a serial session are refused
    task automatic t_block;
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            {in_circuit_programming, onchip_debug_support} <= 2'h2 >> k;
            req_valid <= 1'b1;
            repeat (6) @(negedge clock);
            chk("refused", 0, {req_ready, busy});
            chk("data lines", 0, {prog_serial_data_line_oe,
                debug_data_line_oe, prog_serial_data_line_out,
                debug_data_line_out});
            @(posedge clock);
            {in_circuit_programming, onchip_debug_support} <= 2'h0;
            req_valid <= 1'b0;
        end
    endtask : t_block
    initial begin
        {rst, req_valid, ptr_low_we, ptr_high_we, hold_we} = 5'h10;
        {in_circuit_programming, onchip_debug_support} = 2'h0;
        {prog_serial_data_line_in, prog_serial_clock_line} = 2'h0;
        {debug_data_line_in, debug_clock_line} = 2'h0;
        sfr_wdata = 8'h00;
        req = '0;
        failures = 0;
        compares = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_hold();
        t_ops();
        t_block();
        final_report();
    end
endmodule : ptr_table_reader_tb

// file: hw/ptr_phase_div.sv
`timescale 1ns/10ps
// divides the system clock into instruction cycles
module ptr_phase_div (
    input wire logic clock,
    input wire logic rst,
    output logic cycle_en
);
    import ptr_pkg::*;

    logic [PHASE_W-1:0] phase;

    // free running phase counter
    always_ff @(posedge clock) begin
        if (rst) begin
            phase <= PHASE_RESET;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // one pulse on the last phase of each cycle
    assign cycle_en = (phase == PHASE_LAST);
endmodule : ptr_phase_div

// file: hw/ptr_pkg.sv
// shared types and constants for the table read unit
package ptr_pkg;
    // program memory geometry
    localparam int PM_ADDR_W = 11;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [PM_ADDR_W-1:0] LAST_PAGE_BASE = 11'h700;
    localparam int LAST_PAGE_HI_POS = 8;
    // data memory sector and address widths
    localparam int SECT_W = 3;
    localparam int DM_ADDR_W = 8;
    localparam logic [SECT_W-1:0] SECTOR_ZERO = 3'h0;
    // system clocks per instruction cycle (four phases)
    localparam int PHASES_PER_CYCLE = 4;
    localparam int PHASE_W = 2;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;
    // instruction cycles per table instruction
    localparam int TABLE_CYCLES = 2;
    // reset values
    localparam logic [BYTE_W-1:0] PTR_LOW_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] PTR_HIGH_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] HOLD_RESET = 8'h00;
    localparam logic [PM_ADDR_W-1:0] PM_ADDR_RESET = 11'h000;

    // table read variants
    typedef enum logic [1:0] {
        TABLE_READ_OP = 2'b00,
        TABLE_READ_LAST_PAGE_OP = 2'b01,
        EXTENDED_TABLE_READ_OP = 2'b10,
        EXTENDED_TABLE_READ_LAST_PAGE_OP = 2'b11
    } ptr_op_e;

    // request from instruction execution logic
    typedef struct packed {
        ptr_op_e op;
        logic [SECT_W-1:0] sector;
        logic [DM_ADDR_W-1:0] addr;
    } ptr_req_s;

    // write into data memory
    typedef struct packed {
        logic [SECT_W-1:0] sector;
        logic [DM_ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } ptr_dm_wr_s;
endpackage : ptr_pkg

// file: hw/ptr_table_reader.sv
`timescale 1ns/10ps
// Notes on behaviour
// (R01) address from low and high pointers
// (R02) low word byte written to operand
// (R03) high word byte loads holding register
// (R04) ordinary forms sector 0, extended any sector
// (R05) every table instruction takes two cycles
// (R06) holding register readable and writable
// (R07) 2K words, last page at 0700H
// (R08) programming: one data line, external clock
// (R09) debug: one data line, clock input
// (R10) fetched word is sixteen bits
// (R11) fetch in cycle two, drop high bits
module ptr_table_reader (
    input wire logic clock,
    input wire logic rst,
    // table request from instruction execution
    input wire logic req_valid,
    input wire ptr_pkg::ptr_req_s req,
    output logic req_ready,
    output logic busy,
    output logic done,
    output logic cycle_en,
    // pointer and holding register access
    input wire logic ptr_low_we,
    input wire logic ptr_high_we,
    input wire logic hold_we,
    input wire logic [ptr_pkg::BYTE_W-1:0] sfr_wdata,
    output logic [ptr_pkg::BYTE_W-1:0] ptr_low,
    output logic [ptr_pkg::BYTE_W-1:0] ptr_high,
    output logic [ptr_pkg::BYTE_W-1:0] table_high_byte_hold,
    // program memory read port
    output logic pm_rd,
    output logic [ptr_pkg::PM_ADDR_W-1:0] pm_addr,
    input wire logic [ptr_pkg::WORD_W-1:0] pm_rdata,
    // data memory write port
    output logic dm_we,
    output ptr_pkg::ptr_dm_wr_s dm_wr,
    // serial programming and debug pins
    input wire logic in_circuit_programming,
    input wire logic onchip_debug_support,
    input wire logic prog_serial_data_line_in,
    output logic prog_serial_data_line_out,
    output logic prog_serial_data_line_oe,
    input wire logic prog_serial_clock_line,
    input wire logic debug_data_line_in,
    output logic debug_data_line_out,
    output logic debug_data_line_oe,
    input wire logic debug_clock_line
);
    import ptr_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FIRST = 2'b01,
        ST_FETCH = 2'b10
    } ptr_state_e;

    ptr_state_e state;
    ptr_req_s held_req;
    logic [PM_ADDR_W-1:0] fetch_addr;
    logic [PM_ADDR_W-1:0] next_fetch_addr;
    logic [SECT_W-1:0] next_sector;
    logic data_due;
    logic take;
    logic serial_session;

    // instruction cycle enable
    ptr_phase_div u_phase_div (
        .clock(clock),
        .rst(rst),
        .cycle_en(cycle_en)
    );

    // no table read starts while a serial session owns memory
    assign serial_session = in_circuit_programming | onchip_debug_support;
    assign busy = (state != ST_IDLE);
    assign req_ready = (state == ST_IDLE) && !serial_session;
    // requests start on an instruction cycle boundary
    assign take = req_valid && req_ready && cycle_en;

    // (R01) full pointer address
    // (R11) pointer bits above 11 ignored
    // (R07) last page forms use 0700H
    always_comb begin
        next_fetch_addr = {ptr_high[PM_ADDR_W-BYTE_W-1:0], ptr_low};
        if (req.op == TABLE_READ_LAST_PAGE_OP ||
            req.op == EXTENDED_TABLE_READ_LAST_PAGE_OP) begin
            next_fetch_addr = {LAST_PAGE_BASE[PM_ADDR_W-1:LAST_PAGE_HI_POS],
                ptr_low};
        end
    end

    // (R04) ordinary forms forced to sector 0
    always_comb begin
        next_sector = req.sector;
        if (req.op == TABLE_READ_OP || req.op == TABLE_READ_LAST_PAGE_OP) begin
            next_sector = SECTOR_ZERO;
        end
    end

    // low table pointer
    always_ff @(posedge clock) begin
        if (rst) begin
            ptr_low <= PTR_LOW_RESET;
        end else if (ptr_low_we) begin
            ptr_low <= sfr_wdata;
        end
    end

    // high table pointer
    always_ff @(posedge clock) begin
        if (rst) begin
            ptr_high <= PTR_HIGH_RESET;
        end else if (ptr_high_we) begin
            ptr_high <= sfr_wdata;
        end
    end

    // (R05) two instruction cycles per table op
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        state <= ST_FIRST;
                    end
                end
                ST_FIRST: begin
                    if (cycle_en) begin
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (cycle_en) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // request capture at the start of cycle one
    always_ff @(posedge clock) begin
        if (rst) begin
            held_req <= '0;
            fetch_addr <= PM_ADDR_RESET;
        end else if (take) begin
            held_req.op <= req.op;
            held_req.sector <= next_sector;
            held_req.addr <= req.addr;
            fetch_addr <= next_fetch_addr;
        end
    end

    // (R11) memory read issued as cycle two opens
    always_ff @(posedge clock) begin
        if (rst) begin
            pm_rd <= 1'b0;
            pm_addr <= PM_ADDR_RESET;
        end else begin
            pm_rd <= (state == ST_FIRST) && cycle_en;
            if ((state == ST_FIRST) && cycle_en) begin
                pm_addr <= fetch_addr;
            end
        end
    end

    // memory answers one clock after the read strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            data_due <= 1'b0;
        end else begin
            data_due <= pm_rd;
        end
    end

    // (R02) low byte to operand location
    // (R10) sixteen bit word split in two
    always_ff @(posedge clock) begin
        if (rst) begin
            dm_we <= 1'b0;
            dm_wr <= '0;
        end else begin
            dm_we <= data_due;
            if (data_due) begin
                dm_wr.sector <= held_req.sector;
                dm_wr.addr <= held_req.addr;
                dm_wr.data <= pm_rdata[BYTE_W-1:0];
            end
        end
    end

    // (R03) high byte overwrites holding register
    // (R06) software write restores a saved value
    always_ff @(posedge clock) begin
        if (rst) begin
            table_high_byte_hold <= HOLD_RESET;
        end else if (data_due) begin
            table_high_byte_hold <= pm_rdata[WORD_W-1:BYTE_W];
        end else if (hold_we) begin
            table_high_byte_hold <= sfr_wdata;
        end
    end

    // completion pulse at the end of cycle two
    always_ff @(posedge clock) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= (state == ST_FETCH) && cycle_en;
        end
    end

    // (R08) programming data line left to the programmer
    // (R09) debug data line left to the debug tool
    // the serial protocols live elsewhere; this unit only
    // keeps off the shared lines and holds back table reads
    assign prog_serial_data_line_out = 1'b0;
    assign prog_serial_data_line_oe = 1'b0;
    assign debug_data_line_out = 1'b0;
    assign debug_data_line_oe = 1'b0;
endmodule : ptr_table_reader
